// ### shared/simd_fault_pkg.sv
// Purpose: Shared constants and types for the SIMD extension fault gate
// Assumes: Control and feature words arrive as 32-bit values
// Notes: Exception bit positions index every exception vector in the design
package simd_fault_pkg;

	// Control word bit positions
	localparam int unsigned CR_EM_POS = 2;
	localparam int unsigned CR_TS_POS = 3;
	localparam int unsigned CR_NE_POS = 5;

	// Feature flags word bit positions
	localparam int unsigned FEAT_THIRD_POS = 0;
	localparam int unsigned FEAT_SUPP_POS = 9;
	localparam int unsigned FEAT_L1_POS = 19;
	localparam int unsigned FEAT_L2_POS = 20;

	// Exception vectors
	localparam logic [7:0] VEC_NONE = 8'h00;
	localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
	localparam logic [7:0] VEC_DEVICE_NA = 8'h07;
	localparam logic [7:0] VEC_SIMD_NUMERIC = 8'h13;

	// Numeric exception vector layout
	localparam int unsigned EXC_W = 5;
	localparam int unsigned EXC_OVF = 0;
	localparam int unsigned EXC_UNF = 1;
	localparam int unsigned EXC_INV = 2;
	localparam int unsigned EXC_PRE = 3;
	localparam int unsigned EXC_DEN = 4;

	// Immediate field positions
	localparam int unsigned IMM_ROUND_PRE_POS = 3;
	localparam int unsigned IMM_SEL_LSB = 4;

	// Lanes of the dot product
	localparam int unsigned LANES_SINGLE = 4;
	localparam int unsigned LANES_DOUBLE = 2;

	// Reset values
	localparam logic IGN_PIN_RESET = 1'b1;
	localparam logic [7:0] VEC_RESET = 8'h00;

	typedef enum logic [3:0] {
		CLS_NONE = 4'h0,
		CLS_THIRD = 4'h1,
		CLS_TRUNC_STORE = 4'h2,
		CLS_SUPP = 4'h3,
		CLS_L1_GEN = 4'h4,
		CLS_DOT_SINGLE = 4'h5,
		CLS_DOT_DOUBLE = 4'h6,
		CLS_ROUND_PS = 4'h7,
		CLS_ROUND_SS = 4'h8,
		CLS_ROUND_PD = 4'h9,
		CLS_ROUND_SD = 4'ha,
		CLS_BLEND_INS_EXT = 4'hb,
		CLS_L2_GEN = 4'hc,
		CLS_CHECKSUM = 4'hd,
		CLS_POPCOUNT = 4'he
	} instr_class_t;

endpackage

// ### rtl/ext_fault_decide.sv
// Purpose: Decides invalid-opcode or device-not-available for one issued instruction
// Assumes: Class already decoded; pure combinational
// Notes: Missing feature and emulation both give invalid-opcode, which outranks task switch
`timescale 1ns/1ps
`default_nettype none
module ext_fault_decide
	import simd_fault_pkg::*;
(
	// Instruction
	input wire instr_class_t cls_i,
	// Machine state
	input wire logic [31:0] feature_flags_word_i,
	input wire logic [31:0] control_word_i,
	// Decision
	output logic invalid_opcode_o,
	output logic device_not_available_fault_o,
	output logic [7:0] vector_o
);

	logic feature_missing;
	logic in_extension;
	logic ts_exempt;

	always_comb begin
		feature_missing = 1'b0;
		in_extension = 1'b1;
		ts_exempt = 1'b0;
		case (cls_i)
			CLS_THIRD, CLS_TRUNC_STORE: begin
				feature_missing = ~feature_flags_word_i[FEAT_THIRD_POS];
			end
			CLS_SUPP: begin
				feature_missing = ~feature_flags_word_i[FEAT_SUPP_POS];
			end
			CLS_L1_GEN, CLS_DOT_SINGLE, CLS_DOT_DOUBLE, CLS_ROUND_PS, CLS_ROUND_SS,
			CLS_ROUND_PD, CLS_ROUND_SD, CLS_BLEND_INS_EXT: begin
				feature_missing = ~feature_flags_word_i[FEAT_L1_POS];
			end
			CLS_L2_GEN: begin
				feature_missing = ~feature_flags_word_i[FEAT_L2_POS];
			end
			CLS_CHECKSUM, CLS_POPCOUNT: begin
				ts_exempt = 1'b1;
			end
			default: begin
				in_extension = 1'b0;
			end
		endcase
	end

	always_comb begin
		invalid_opcode_o = 1'b0;
		device_not_available_fault_o = 1'b0;
		vector_o = VEC_NONE;
		if (in_extension) begin
			if (feature_missing || control_word_i[CR_EM_POS]) begin
				invalid_opcode_o = 1'b1;
				vector_o = VEC_INVALID_OPCODE;
			end else if (control_word_i[CR_TS_POS] && !ts_exempt) begin
				device_not_available_fault_o = 1'b1;
				vector_o = VEC_DEVICE_NA;
			end
		end
	end

endmodule
`default_nettype wire

// ### rtl/simd_exc_filter.sv
// Purpose: Selects the numeric exception classes an instruction may report
// Assumes: Raw flags come from the arithmetic datapath in the same cycle
// Notes: Per-lane input flags only count for lanes the immediate selects
`timescale 1ns/1ps
`default_nettype none
module simd_exc_filter
	import simd_fault_pkg::*;
#(
	parameter int unsigned LANES = LANES_SINGLE
) (
	// Instruction
	input wire instr_class_t cls_i,
	input wire logic [7:0] imm_i,
	// Mode bits
	input wire logic flush_to_zero_i,
	input wire logic denormals_as_zero_i,
	// Raw datapath flags
	input wire logic [EXC_W-1:0] raw_exc_i,
	input wire logic [LANES-1:0] lane_inv_i,
	input wire logic [LANES-1:0] lane_den_i,
	input wire logic [LANES-1:0] lane_nan_i,
	input wire logic src_signalling_nan_i,
	// Filtered result
	output logic [EXC_W-1:0] exc_o,
	output logic [LANES-1:0] lane_zero_o,
	output logic chained_round_o,
	output logic nan_required_o
);

	logic is_dot;
	logic [LANES-1:0] lane_sel;

	assign is_dot = (cls_i == CLS_DOT_SINGLE) || (cls_i == CLS_DOT_DOUBLE);

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		assign lane_sel[i] = imm_i[IMM_SEL_LSB + i] &&
			((cls_i == CLS_DOT_SINGLE) || ((cls_i == CLS_DOT_DOUBLE) && (i < LANES_DOUBLE)));
		assign lane_zero_o[i] = is_dot && !lane_sel[i];
	end

	assign chained_round_o = is_dot && !flush_to_zero_i && !denormals_as_zero_i;
	assign nan_required_o = is_dot && |(lane_nan_i & lane_sel);

	always_comb begin
		exc_o = '0;
		case (cls_i)
			CLS_DOT_SINGLE, CLS_DOT_DOUBLE: begin
				exc_o[EXC_OVF] = raw_exc_i[EXC_OVF];
				exc_o[EXC_UNF] = raw_exc_i[EXC_UNF];
				exc_o[EXC_PRE] = raw_exc_i[EXC_PRE];
				exc_o[EXC_INV] = raw_exc_i[EXC_INV] || |(lane_inv_i & lane_sel);
				exc_o[EXC_DEN] = |(lane_den_i & lane_sel);
			end
			CLS_ROUND_PS, CLS_ROUND_SS, CLS_ROUND_PD, CLS_ROUND_SD: begin
				exc_o[EXC_INV] = src_signalling_nan_i;
				exc_o[EXC_PRE] = raw_exc_i[EXC_PRE] && !imm_i[IMM_ROUND_PRE_POS];
			end
			CLS_THIRD, CLS_TRUNC_STORE: begin
				exc_o = raw_exc_i;
			end
			default: begin
				exc_o = '0;
			end
		endcase
	end

endmodule
`default_nettype wire

// ### rtl/simd_extension_fault_gate.sv
// Purpose: Qualifies faults and numeric exceptions for later SIMD extensions
// Assumes: One instruction offered per enabled cycle; answer one edge later
// Notes: Ignore pin is asynchronous and passes a three-stage synchroniser
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Task-switched bit set on extension issue raises device-not-available fault.
// - Third-set feature flag clear makes its instructions invalid-opcode.
// - Supplemental-set feature flag clear makes its instructions invalid-opcode.
// - First-level fourth-set flag clear makes its instructions invalid-opcode.
// - Second-level flag clear makes compare and string instructions invalid-opcode.
// - Checksum and population count never raise device-not-available.
// - Third set except the truncating store forces numeric-error bit, ignores pin, reports vector 19.
// - Supplemental set forces numeric-error bit and ignores the pin.
// - Supplemental and second-level instructions never raise floating-point errors.
// - Emulation bit set turns any extension fault into invalid-opcode.
// - Dot-product select bits zero unselected lanes and mute their exceptions.
// - Without flush or denormal modes dot products round each stage.
// - Dot product with any exception leaves destination unwritten.
// - Dot products may report overflow, underflow, invalid, precision, denormal.
// - Round operations report only invalid and precision.
// - Round reports invalid only for a signalling NaN source.
// - Round immediate bit 3 suppresses precision regardless of mask.
// - Blend, insert and extract never report numeric exceptions.
module simd_extension_fault_gate
	import simd_fault_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	// Issue from decode
	input wire logic issue_valid_i,
	input wire instr_class_t instr_class_i,
	input wire logic [7:0] imm_i,
	// Architectural state
	input wire logic [31:0] feature_flags_word_i,
	input wire logic [31:0] control_word_i,
	input wire logic flush_to_zero_i,
	input wire logic denormals_as_zero_i,
	input wire logic ignore_numeric_error_pin_n_i,
	// Datapath flags
	input wire logic [EXC_W-1:0] raw_exc_i,
	input wire logic [LANES_SINGLE-1:0] lane_inv_i,
	input wire logic [LANES_SINGLE-1:0] lane_den_i,
	input wire logic [LANES_SINGLE-1:0] lane_nan_i,
	input wire logic src_signalling_nan_i,
	// Fault answer
	output logic result_valid_o,
	output logic invalid_opcode_o,
	output logic device_not_available_fault_o,
	output logic [7:0] fault_vector_o,
	output logic dest_write_en_o,
	// Numeric answer
	output logic [EXC_W-1:0] simd_exc_o,
	output logic [LANES_SINGLE-1:0] lane_zero_o,
	output logic chained_round_o,
	output logic nan_required_o,
	output logic numeric_error_ctl_bit_o,
	output logic err_vector19_o,
	output logic err_x87_o
);

	logic ign_s1_q;
	logic ign_s2_q;
	logic ign_s3_q;
	logic ign_n_q;
	logic dec_ud;
	logic dec_dna;
	logic [7:0] dec_vec;
	logic [EXC_W-1:0] flt_exc;
	logic [LANES_SINGLE-1:0] flt_zero;
	logic flt_chain;
	logic flt_nan;
	logic is_dot;
	logic is_trunc;
	logic simd_reports;
	logic ne_forced;
	logic ne_eff;
	logic any_exc;
	logic fault_d;

	ext_fault_decide u_decide (
		.cls_i(instr_class_i),
		.feature_flags_word_i(feature_flags_word_i),
		.control_word_i(control_word_i),
		.invalid_opcode_o(dec_ud),
		.device_not_available_fault_o(dec_dna),
		.vector_o(dec_vec)
	);

	simd_exc_filter #(
		.LANES(LANES_SINGLE)
	) u_filter (
		.cls_i(instr_class_i),
		.imm_i(imm_i),
		.flush_to_zero_i(flush_to_zero_i),
		.denormals_as_zero_i(denormals_as_zero_i),
		.raw_exc_i(raw_exc_i),
		.lane_inv_i(lane_inv_i),
		.lane_den_i(lane_den_i),
		.lane_nan_i(lane_nan_i),
		.src_signalling_nan_i(src_signalling_nan_i),
		.exc_o(flt_exc),
		.lane_zero_o(flt_zero),
		.chained_round_o(flt_chain),
		.nan_required_o(flt_nan)
	);

	// Ignore pin synchroniser; value moves only when stages two and three agree
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ign_s1_q <= IGN_PIN_RESET;
			ign_s2_q <= IGN_PIN_RESET;
			ign_s3_q <= IGN_PIN_RESET;
			ign_n_q <= IGN_PIN_RESET;
		end else if (clk_en_i) begin
			ign_s1_q <= ignore_numeric_error_pin_n_i;
			ign_s2_q <= ign_s1_q;
			ign_s3_q <= ign_s2_q;
			if (ign_s2_q == ign_s3_q) begin
				ign_n_q <= ign_s3_q;
			end
		end
	end

	assign is_dot = (instr_class_i == CLS_DOT_SINGLE) || (instr_class_i == CLS_DOT_DOUBLE);
	assign is_trunc = instr_class_i == CLS_TRUNC_STORE;
	assign fault_d = dec_ud || dec_dna;
	assign any_exc = |flt_exc;

	assign ne_forced = (instr_class_i == CLS_THIRD) || (instr_class_i == CLS_SUPP);
	assign ne_eff = ne_forced || control_word_i[CR_NE_POS];
	assign simd_reports = (instr_class_i == CLS_THIRD) || is_dot ||
		(instr_class_i == CLS_ROUND_PS) || (instr_class_i == CLS_ROUND_SS) ||
		(instr_class_i == CLS_ROUND_PD) || (instr_class_i == CLS_ROUND_SD);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			result_valid_o <= 1'b0;
			invalid_opcode_o <= 1'b0;
			device_not_available_fault_o <= 1'b0;
			fault_vector_o <= VEC_RESET;
			dest_write_en_o <= 1'b0;
		end else if (clk_en_i) begin
			result_valid_o <= issue_valid_i;
			invalid_opcode_o <= issue_valid_i && dec_ud;
			device_not_available_fault_o <= issue_valid_i && dec_dna;
			fault_vector_o <= issue_valid_i ? dec_vec : VEC_NONE;
			dest_write_en_o <= issue_valid_i && !fault_d && !(is_dot && any_exc);
		end
	end

	// Numeric exception and error flags are dropped when the instruction faults, since it never runs
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			simd_exc_o <= '0;
			lane_zero_o <= '0;
			chained_round_o <= 1'b0;
			nan_required_o <= 1'b0;
			numeric_error_ctl_bit_o <= 1'b0;
			err_vector19_o <= 1'b0;
			err_x87_o <= 1'b0;
		end else if (clk_en_i) begin
			simd_exc_o <= (issue_valid_i && !fault_d) ? flt_exc : '0;
			lane_zero_o <= issue_valid_i ? flt_zero : '0;
			chained_round_o <= issue_valid_i && flt_chain;
			nan_required_o <= issue_valid_i && flt_nan;
			numeric_error_ctl_bit_o <= ne_eff;
			// vector 19 path ignores the pin
			err_vector19_o <= issue_valid_i && !fault_d && simd_reports && any_exc;
			// x87-style store still honours the control bit and the pin
			err_x87_o <= issue_valid_i && !fault_d && is_trunc && any_exc &&
				(control_word_i[CR_NE_POS] || ign_n_q);
		end
	end

	a_ts_fault: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && control_word_i[CR_TS_POS] && !control_word_i[CR_EM_POS]
		&& instr_class_i == CLS_SUPP && feature_flags_word_i[FEAT_SUPP_POS]
		|=> device_not_available_fault_o && fault_vector_o == 8'h07)
		else $error("task switch did not raise device fault");

	a_third_missing: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_THIRD
		&& !feature_flags_word_i[FEAT_THIRD_POS]
		|=> invalid_opcode_o && !device_not_available_fault_o && !dest_write_en_o)
		else $error("missing third set did not raise invalid opcode");

	a_supp_missing: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_SUPP
		&& !feature_flags_word_i[FEAT_SUPP_POS]
		|=> invalid_opcode_o && fault_vector_o == 8'h06)
		else $error("missing supplemental set did not raise invalid opcode");

	a_l1_missing: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_DOT_SINGLE
		&& !feature_flags_word_i[FEAT_L1_POS]
		|=> invalid_opcode_o && simd_exc_o == 5'h00)
		else $error("missing first level did not raise invalid opcode");

	a_l2_missing: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_L2_GEN
		&& !feature_flags_word_i[FEAT_L2_POS]
		|=> invalid_opcode_o)
		else $error("missing second level did not raise invalid opcode");

	a_ts_exempt: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i
		&& (instr_class_i == CLS_CHECKSUM || instr_class_i == CLS_POPCOUNT)
		|=> !device_not_available_fault_o)
		else $error("checksum or population count raised device fault");

	a_em_wins: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && control_word_i[CR_EM_POS]
		&& instr_class_i != CLS_NONE
		|=> invalid_opcode_o && !device_not_available_fault_o)
		else $error("emulation bit did not give invalid opcode");

	a_dot_keep: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && is_dot && !fault_d
		##1 simd_exc_o != 5'h00
		|-> !dest_write_en_o)
		else $error("dot product with exception wrote destination");

	a_round_only: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && $past(clk_en_i) && instr_class_i inside
		{CLS_ROUND_PS, CLS_ROUND_SS, CLS_ROUND_PD, CLS_ROUND_SD}
		|=> (simd_exc_o & 5'h13) == 5'h00)
		else $error("round reported overflow, underflow or denormal");

	a_round_pre: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && imm_i[3] && instr_class_i inside
		{CLS_ROUND_PS, CLS_ROUND_SS, CLS_ROUND_PD, CLS_ROUND_SD}
		|=> !simd_exc_o[3])
		else $error("round precision not suppressed by immediate");

	a_silent_set: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && (instr_class_i == CLS_BLEND_INS_EXT
		|| instr_class_i == CLS_SUPP || instr_class_i == CLS_L2_GEN)
		|=> simd_exc_o == 5'h00 && !err_vector19_o && !err_x87_o)
		else $error("silent instruction reported numeric exception");

	a_lane_mute: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_DOT_SINGLE
		&& imm_i[7:4] == 4'h0 && !fault_d
		|=> lane_zero_o == 4'hf && !simd_exc_o[4])
		else $error("unselected lanes not zeroed or muted");

	a_chain_mode: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_DOT_DOUBLE
		|=> chained_round_o == (!$past(flush_to_zero_i) && !$past(denormals_as_zero_i)))
		else $error("dot product rounding mode wrong");

	a_third_vec19: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_THIRD && !fault_d
		&& raw_exc_i != 5'h00
		|=> err_vector19_o && numeric_error_ctl_bit_o && !err_x87_o)
		else $error("third set error not sent to vector 19");

	a_supp_ne: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && instr_class_i == CLS_SUPP
		|=> numeric_error_ctl_bit_o)
		else $error("supplemental set did not force numeric-error bit");

	a_l2_no_err: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i
		&& (instr_class_i == CLS_CHECKSUM || instr_class_i == CLS_POPCOUNT)
		|=> simd_exc_o == 5'h00 && !err_vector19_o && !err_x87_o)
		else $error("second level instruction reported floating-point error");

	a_round_inv: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && !src_signalling_nan_i && instr_class_i inside
		{CLS_ROUND_PS, CLS_ROUND_SS, CLS_ROUND_PD, CLS_ROUND_SD}
		|=> !simd_exc_o[2])
		else $error("round reported invalid without signalling NaN source");

	a_dot_double: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && instr_class_i == CLS_DOT_DOUBLE
		|=> lane_zero_o[3:2] == 2'h3)
		else $error("double dot product used upper lanes");

	a_fault_quiet: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && issue_valid_i && fault_d
		|=> !dest_write_en_o && simd_exc_o == 5'h00 && !err_vector19_o && !err_x87_o)
		else $error("faulting instruction updated state");

	a_no_issue: assert property (
		@(posedge ref_clk_i) disable iff (reset_i)
		clk_en_i && !issue_valid_i
		|=> !result_valid_o && !invalid_opcode_o && !device_not_available_fault_o
		&& !dest_write_en_o)
		else $error("answer without an issued instruction");

endmodule
`default_nettype wire

// ### bench/decode_pipe_model.sv
// Purpose: Decode and execute pipeline model that offers instructions to the gate
// Assumes: Every offer changes just after a rising clock edge
// Notes: Datapath flags belong to the cycle of the offer they go with
`timescale 1ns/1ps
`default_nettype none
module decode_pipe_model
	import simd_fault_pkg::*;
(
	// Issue
	output var logic issue_valid_o,
	output var instr_class_t class_o,
	output var logic [7:0] imm_o,
	// Machine state
	output var logic [31:0] feat_o,
	output var logic [31:0] ctrl_o,
	// Datapath flags
	output var logic [EXC_W-1:0] raw_exc_o,
	output var logic [LANES_SINGLE-1:0] lane_inv_o,
	output var logic [LANES_SINGLE-1:0] lane_den_o,
	output var logic [LANES_SINGLE-1:0] lane_nan_o,
	output var logic sig_nan_o
);
	task automatic offer(input instr_class_t c, input logic [7:0] i, input logic [31:0] f,
		input logic [31:0] w);
		issue_valid_o = 1'b1;
		class_o = c;
		imm_o = i;
		feat_o = f;
		ctrl_o = w;
	endtask

	task automatic flags(input logic [4:0] r, input logic [3:0] li, input logic [3:0] ld,
		input logic [3:0] ln, input logic sn);
		raw_exc_o = r;
		lane_inv_o = li;
		lane_den_o = ld;
		lane_nan_o = ln;
		sig_nan_o = sn;
	endtask

	// Stale flags are inverted so an idle cycle never shows the last offer's values
	task automatic drop();
		issue_valid_o = 1'b0;
		flags(~raw_exc_o, ~lane_inv_o, ~lane_den_o, ~lane_nan_o, ~sig_nan_o);
	endtask

	initial begin
		offer(CLS_NONE, 8'h00, 32'h0000_0000, 32'h0000_0000);
		issue_valid_o = 1'b0;
		flags(5'h00, 4'h0, 4'h0, 4'h0, 1'b0);
	end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the SIMD extension fault gate
// Assumes: Answers come one enabled edge after the offer
// Notes: Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	import simd_fault_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic clk_en_i = 1'b1;
	logic pin_n = 1'b1;
	logic flush_zero = 1'b0;
	logic denorm_zero = 1'b0;
	wire logic iv, sig_nan, rv, inv_o, dna, dwe, chr, nanr, ne, e19, ex87;
	wire instr_class_t cls;
	wire logic [7:0] imm, vec;
	wire logic [31:0] feat, ctrl;
	wire logic [4:0] raw, exc;
	wire logic [3:0] linv, lden, lnan, lz;
	int fail_count = 0;
	int cmp_count = 0;

	always #50 ref_clk_i = ~ref_clk_i;

	decode_pipe_model pipe (.issue_valid_o(iv), .class_o(cls), .imm_o(imm), .feat_o(feat),
		.ctrl_o(ctrl), .raw_exc_o(raw), .lane_inv_o(linv), .lane_den_o(lden),
		.lane_nan_o(lnan), .sig_nan_o(sig_nan));

	simd_extension_fault_gate dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.clk_en_i(clk_en_i), .issue_valid_i(iv), .instr_class_i(cls), .imm_i(imm),
		.feature_flags_word_i(feat), .control_word_i(ctrl), .flush_to_zero_i(flush_zero),
		.denormals_as_zero_i(denorm_zero), .ignore_numeric_error_pin_n_i(pin_n),
		.raw_exc_i(raw), .lane_inv_i(linv), .lane_den_i(lden), .lane_nan_i(lnan),
		.src_signalling_nan_i(sig_nan),
		.result_valid_o(rv), .invalid_opcode_o(inv_o), .device_not_available_fault_o(dna),
		.fault_vector_o(vec), .dest_write_en_o(dwe), .simd_exc_o(exc), .lane_zero_o(lz),
		.chained_round_o(chr), .nan_required_o(nanr), .numeric_error_ctl_bit_o(ne),
		.err_vector19_o(e19), .err_x87_o(ex87));

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic step();
		@(posedge ref_clk_i);
		#1;
	endtask

	// Offers back to back: valid stays up between calls
	task automatic go(input instr_class_t c, input logic [7:0] i, input logic [31:0] f,
		input logic [31:0] w);
		pipe.offer(c, i, f, w);
		step();
		chk("result_valid", rv, 32'h1);
	endtask

	task automatic num(input instr_class_t c, input logic [7:0] i, input logic [31:0] w,
		input logic [4:0] r, input logic [3:0] li, input logic [3:0] ld, input logic [3:0] ln,
		input logic sn, input logic [4:0] ee, input logic ew);
		pipe.flags(r, li, ld, ln, sn);
		go(c, i, 32'hffff_ffff, w);
		chk("simd_exc", exc, ee);
		chk("dest_write", dwe, ew);
	endtask

	// Feature bit a class depends on; all ones where none gates it
	function automatic logic [31:0] need(input instr_class_t c);
		case (c)
			CLS_THIRD, CLS_TRUNC_STORE: return 32'h1 << FEAT_THIRD_POS;
			CLS_SUPP: return 32'h1 << FEAT_SUPP_POS;
			CLS_L2_GEN: return 32'h1 << FEAT_L2_POS;
			CLS_CHECKSUM, CLS_POPCOUNT, CLS_NONE: return 32'hffff_ffff;
			default: return 32'h1 << FEAT_L1_POS;
		endcase
	endfunction

	function automatic logic [1:0] fexp(input instr_class_t c, input logic [31:0] f,
		input logic [31:0] w);
		logic any, unchk, bad;
		any = (c != CLS_NONE);
		unchk = (c == CLS_CHECKSUM) || (c == CLS_POPCOUNT) || (c == CLS_NONE);
		bad = any && (w[CR_EM_POS] || (!unchk && ((f & need(c)) != need(c))));
		return {bad, any && !unchk && !bad && w[CR_TS_POS]};
	endfunction

	initial begin
		repeat (2000) @(posedge ref_clk_i);
		fail_count++;
		stop_test();
	end

	initial begin
		instr_class_t c;
		logic [31:0] f;
		logic [31:0] w;
		logic [1:0] e;
		instr_class_t quiet [5];
		quiet = '{CLS_BLEND_INS_EXT, CLS_SUPP, CLS_L2_GEN, CLS_CHECKSUM, CLS_POPCOUNT};
		repeat (20) @(posedge ref_clk_i);
		#1;
		chk("reset_valid", rv, 32'h0);
		reset_i = 1'b0;
		for (int k = 0; k < 15; k++) begin
			c = instr_class_t'(k);
			for (int m = 0; m < 8; m++) begin
				f = m[2] ? ~need(c) : 32'hffff_ffff;
				w = 32'(m[1:0]) << CR_EM_POS;
				e = fexp(c, f, w);
				go(c, 8'h00, f, w);
				chk("invalid_opcode", inv_o, e[1]);
				chk("dev_not_avail", dna, e[0]);
				chk("vector", vec, e[1] ? 32'h06 : (e[0] ? 32'h07 : 32'h00));
				chk("dest_write", dwe, !(e[1] || e[0]));
			end
		end
		num(CLS_ROUND_PS, 8'h00, 0, 5'h1f, 0, 0, 0, 1'b0, 5'h08, 1'b1);
		num(CLS_ROUND_SD, 8'h08, 0, 5'h1f, 0, 0, 0, 1'b1, 5'h04, 1'b1);
		num(CLS_ROUND_SS, 8'h08, 0, 5'h1f, 0, 0, 0, 1'b0, 5'h00, 1'b1);
		num(CLS_ROUND_PD, 8'h00, 0, 5'h1f, 0, 0, 0, 1'b1, 5'h0c, 1'b1);
		foreach (quiet[q]) begin
			num(quiet[q], 8'h00, 0, 5'h1f, 4'hf, 4'hf, 4'hf, 1'b1, 5'h00, 1'b1);
		end
		num(CLS_DOT_SINGLE, 8'h30, 0, 5'h0b, 4'hc, 0, 0, 1'b0, 5'h0b, 1'b0);
		chk("lane_zero", lz, 32'hc);
		chk("chained", chr, 32'h1);
		num(CLS_DOT_SINGLE, 8'hf0, 0, 5'h00, 0, 4'h1, 4'h2, 1'b0, 5'h10, 1'b0);
		chk("nan_req", nanr, 32'h1);
		num(CLS_DOT_DOUBLE, 8'hf0, 0, 5'h00, 4'h6, 4'h8, 0, 1'b0, 5'h04, 1'b0);
		chk("lane_zero", lz, 32'hc);
		flush_zero = 1'b1;
		num(CLS_DOT_DOUBLE, 8'h10, 0, 5'h00, 4'h2, 0, 0, 1'b0, 5'h00, 1'b1);
		chk("lane_zero", lz, 32'he);
		chk("chained", chr, 32'h0);
		flush_zero = 1'b0;
		// Denormal mode alone must also stop chained rounding
		denorm_zero = 1'b1;
		num(CLS_DOT_DOUBLE, 8'hf0, 0, 5'h00, 0, 0, 0, 1'b0, 5'h00, 1'b1);
		chk("chained", chr, 32'h0);
		chk("nan_req", nanr, 32'h0);
		denorm_zero = 1'b0;
		num(CLS_THIRD, 8'h00, 0, 5'h04, 0, 0, 0, 1'b0, 5'h04, 1'b1);
		chk("vector19", e19, 32'h1);
		chk("ne_bit", ne, 32'h1);
		num(CLS_TRUNC_STORE, 8'h00, 0, 5'h04, 0, 0, 0, 1'b0, 5'h04, 1'b1);
		chk("x87_err", ex87, 32'h1);
		chk("ne_bit", ne, 32'h0);
		// Pin change needs four enabled edges through the synchroniser
		pin_n = 1'b0;
		pipe.drop();
		repeat (4) step();
		chk("idle_valid", rv, 32'h0);
		num(CLS_THIRD, 8'h00, 0, 5'h04, 0, 0, 0, 1'b0, 5'h04, 1'b1);
		chk("vector19", e19, 32'h1);
		num(CLS_SUPP, 8'h00, 0, 5'h04, 0, 0, 0, 1'b0, 5'h00, 1'b1);
		chk("ne_bit", ne, 32'h1);
		num(CLS_TRUNC_STORE, 8'h00, 0, 5'h04, 0, 0, 0, 1'b0, 5'h04, 1'b1);
		chk("x87_err", ex87, 32'h0);
		chk("vector19", e19, 32'h0);
		num(CLS_TRUNC_STORE, 8'h00, 32'h20, 5'h04, 0, 0, 0, 1'b0, 5'h04, 1'b1);
		chk("x87_err", ex87, 32'h1);
		go(CLS_SUPP, 8'h00, 32'hffff_ffff, 32'h8);
		// Enable low must hold the fault answer
		clk_en_i = 1'b0;
		pipe.drop();
		repeat (2) step();
		chk("frozen_dna", dna, 32'h1);
		clk_en_i = 1'b1;
		step();
		chk("idle_valid", rv, 32'h0);
		chk("idle_vector", vec, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
